/* hw/irq_seq_pkg.sv */
package irq_seq_pkg;

    // source count, sources and fixed priority (index 0 highest)
    localparam int unsigned NUM_SRC        = 16;
    localparam logic [3:0]  SRC_SOFT       = 4'h0;
    localparam logic [3:0]  SRC_BAD_OPCODE = 4'h1;
    localparam logic [3:0]  SRC_FETCH_TRAP = 4'h2;
    localparam logic [3:0]  FIRST_MASKABLE = 4'h4;

    // acceptance timing
    localparam int unsigned ACCEPT_MCYCLES = 8;
    localparam int unsigned CLK_PER_MCYCLE = 4;
    localparam int unsigned ACCEPT_CLKS    = ACCEPT_MCYCLES * CLK_PER_MCYCLE;
    localparam logic [5:0]  ACCEPT_LAST    = 6'(ACCEPT_CLKS - 1);
    localparam logic [1:0]  MCYC_LAST      = 2'(CLK_PER_MCYCLE - 1);

    // stack frame
    localparam logic [7:0]  FRAME_BYTES    = 8'h03;
    localparam logic [7:0]  OPC_SOFT_TRAP  = 8'hFF;
    localparam logic [15:0] VECTOR_TOP     = 16'hFFFE;

    // special addresses
    localparam logic [15:0] ENABLE_LOW_ADDR  = 16'h003A;
    localparam logic [15:0] ENABLE_HIGH_ADDR = 16'h003B;
    localparam logic [15:0] LATCH_LOW_ADDR   = 16'h003C;
    localparam logic [15:0] LATCH_HIGH_ADDR  = 16'h003D;
    localparam logic [15:0] SFR_END          = 16'h003F;

    // AXI4-Lite register byte addresses
    localparam logic [7:0]  REG_ENABLE   = 8'h00;
    localparam logic [7:0]  REG_PENDING  = 8'h04;
    localparam logic [7:0]  REG_CONTROL  = 8'h08;
    localparam logic [7:0]  REG_STATUS   = 8'h0C;
    localparam logic [7:0]  REG_SAVED_PC = 8'h10;

    localparam logic [15:0] ENABLE_RESET  = 16'h0000;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [2:0] {
        ST_RUN    = 3'b000,
        ST_ACCEPT = 3'b001,
        ST_RETURN = 3'b010
    } seq_state_t;

    // one stack write or read issued to the cpu memory port
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  data;
    } stack_op_t;

    // fetch events from the cpu pipeline
    typedef struct packed {
        logic        fetch;
        logic        exec_end;
        logic [7:0]  opcode;
        logic        opcode_undef;
        logic [15:0] fetch_addr;
        logic        is_return;
        logic        return_nmi;
    } cpu_evt_t;

endpackage

/* hw/fetch_trap_detect.sv */
`timescale 1ns/1ps
module fetch_trap_detect #(
    parameter logic [15:0] RAM_LO = 16'h0040,
    parameter logic [15:0] RAM_HI = 16'h023F,
    parameter logic [15:0] DBR_LO = 16'h0F80,
    parameter logic [15:0] DBR_HI = 16'h0FFF
) (
    // fetch
    input  wire logic        i_fetch,
    input  wire logic [15:0] i_addr,
    // result
    output logic             o_trap
);
    wire in_sfr = i_addr <= irq_seq_pkg::SFR_END;
    wire in_ram = (i_addr >= RAM_LO) && (i_addr <= RAM_HI);
    wire in_dbr = (i_addr >= DBR_LO) && (i_addr <= DBR_HI);
    assign o_trap = i_fetch && (in_sfr || in_ram || in_dbr);
endmodule

/* hw/irq_priority.sv */
`timescale 1ns/1ps
module irq_priority #(
    parameter int unsigned N = 16
) (
    // requests
    input  wire logic [N-1:0] i_req,
    // winner
    output logic              o_any,
    output logic [3:0]        o_idx
);
    logic [3:0] idx_chain [N:0];
    assign idx_chain[N] = 4'h0;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pri
            // lowest index wins
            assign idx_chain[g] = i_req[g] ? 4'(g) : idx_chain[g+1];
        end
    endgenerate
    assign o_any = |i_req;
    assign o_idx = idx_chain[0];
endmodule

/* hw/irq_sequencer.sv */
// Notes on behaviour
// - Set latch holds until accepted, reset or software clear.
// - Acceptance lasts 8 machine cycles after the instruction ends.
// - Acceptance clears master enable.
// - Acceptance clears only the winner's latch.
// - Push status, pc high, pc low; sp minus 3.
// - Winner's vector slot loads the pc.
// - Enabled request accepted within 38 clocks of latching.
// - Master enable 0 blocks all maskable requests.
// - Hardware saves only pc and status word.
// - Returns pop pc and status with enable; sp plus 3.
// - After acceptance pc low at sp+1, pc high at sp+2.
// - Requests sampled in each instruction's final cycle.
// - Soft trap starts soft interrupt at once, highest priority.
// - Nonexistent memory fetch reads FF, the soft trap.
// - Fetch from RAM, data buffer or special region traps.
// - Undefined opcode raises bad opcode interrupt at once.
// - Address trap gives reset or interrupt per control bit.
// - Master enable is enable bit 0, reset 0.
// - Writes never set latches; 0 clears; latches readable.
`timescale 1ns/1ps
module irq_sequencer #(
    parameter int unsigned N_SRC = irq_seq_pkg::NUM_SRC
) (
    // clock and reset
    input  wire logic                  I_CLOCK,
    input  wire logic                  I_RST,
    // axi4-lite slave
    input  wire logic [7:0]            I_AWADDR,
    input  wire logic                  I_AWVALID,
    output logic                       O_AWREADY,
    input  wire logic [31:0]           I_WDATA,
    input  wire logic [3:0]            I_WSTRB,
    input  wire logic                  I_WVALID,
    output logic                       O_WREADY,
    output logic [1:0]                 O_BRESP,
    output logic                       O_BVALID,
    input  wire logic                  I_BREADY,
    input  wire logic [7:0]            I_ARADDR,
    input  wire logic                  I_ARVALID,
    output logic                       O_ARREADY,
    output logic [31:0]                O_RDATA,
    output logic [1:0]                 O_RRESP,
    output logic                       O_RVALID,
    input  wire logic                  I_RREADY,
    // peripheral request strobes
    input  wire logic [N_SRC-1:0]      I_IRQ_SET,
    // cpu pipeline
    input  wire irq_seq_pkg::cpu_evt_t I_CPU,
    input  wire logic                  I_MEM_EXISTS,
    input  wire logic [15:0]           I_PC,
    input  wire logic [7:0]            I_SP,
    input  wire logic [7:0]            I_STATUS,
    input  wire logic [7:0]            I_STACK_RDATA,
    input  wire logic [15:0]           I_VECTOR,
    // sequencer outputs
    output irq_seq_pkg::stack_op_t     O_STACK,
    output logic [15:0]                O_VECTOR_ADDR,
    output logic                       O_PC_LOAD,
    output logic [15:0]                O_PC_VALUE,
    output logic                       O_SP_LOAD,
    output logic [7:0]                 O_SP_VALUE,
    output logic                       O_STATUS_LOAD,
    output logic [7:0]                 O_STATUS_VALUE,
    output logic                       O_HOLD_CPU,
    output logic                       O_ABORT_INSTR,
    output logic [7:0]                 O_FETCH_OPCODE,
    output logic                       O_TRAP_RESET
);
    ////////////////////////////////////////////////////////////////////////////
    // control registers
    logic [N_SRC-1:0] pend_q;
    logic [N_SRC-1:0] pend_d;
    logic [15:0]      enable_q;
    logic             trap_as_irq_q;
    logic [15:0]      saved_pc_q;
    logic [7:0]       saved_sp_q;
    logic [7:0]       saved_st_q;
    logic [3:0]       src_q;
    logic [5:0]       cnt_q;
    logic             nmi_active_q;
    irq_seq_pkg::seq_state_t state_q;

    wire master_en = enable_q[0];

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: answer one cycle after take
    logic       bvalid_q;
    logic       rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] bresp_q;
    logic [1:0] rresp_q;

    wire wr_fire = I_AWVALID && I_WVALID && !bvalid_q;
    wire rd_fire = I_ARVALID && !rvalid_q;
    wire wr_en   = wr_fire && (I_AWADDR == irq_seq_pkg::REG_ENABLE);
    wire wr_pend = wr_fire && (I_AWADDR == irq_seq_pkg::REG_PENDING);
    wire wr_ctl  = wr_fire && (I_AWADDR == irq_seq_pkg::REG_CONTROL);
    wire wr_ok   = wr_en || wr_pend || wr_ctl;
    wire wr_lo   = I_WSTRB[0];
    wire wr_hi   = I_WSTRB[1];

    assign O_AWREADY = wr_fire;
    assign O_WREADY  = wr_fire;
    assign O_ARREADY = rd_fire;
    assign O_BVALID  = bvalid_q;
    assign O_BRESP   = bresp_q;
    assign O_RVALID  = rvalid_q;
    assign O_RDATA   = rdata_q;
    assign O_RRESP   = rresp_q;

    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb begin
        rd_ok  = 1'b1;
        rd_mux = 32'h0;
        case (I_ARADDR)
            irq_seq_pkg::REG_ENABLE:   rd_mux = {16'h0, enable_q};
            irq_seq_pkg::REG_PENDING:  rd_mux = 32'(pend_q);
            irq_seq_pkg::REG_CONTROL:  rd_mux = {31'h0, trap_as_irq_q};
            irq_seq_pkg::REG_STATUS:   rd_mux = {24'h0, src_q, 1'b0, nmi_active_q, state_q[1:0]};
            irq_seq_pkg::REG_SAVED_PC: rd_mux = {16'h0, saved_pc_q};
            default:                   rd_ok  = 1'b0;
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            bresp_q  <= irq_seq_pkg::RESP_OKAY;
            rresp_q  <= irq_seq_pkg::RESP_OKAY;
            rdata_q  <= 32'h0;
        end else begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? irq_seq_pkg::RESP_OKAY : irq_seq_pkg::RESP_SLVERR;
            end else if (I_BREADY) begin
                bvalid_q <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_mux;
                rresp_q  <= rd_ok ? irq_seq_pkg::RESP_OKAY : irq_seq_pkg::RESP_SLVERR;
            end else if (I_RREADY) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fetch classification
    logic fetch_trap;
    fetch_trap_detect u_trap (
        .i_fetch (I_CPU.fetch),
        .i_addr  (I_CPU.fetch_addr),
        .o_trap  (fetch_trap)
    );

    // nonexistent memory reads back the soft trap opcode
    wire [7:0] opcode_eff = (I_CPU.fetch && !I_MEM_EXISTS) ?
                            irq_seq_pkg::OPC_SOFT_TRAP : I_CPU.opcode;
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) O_FETCH_OPCODE <= 8'h00;
        else if (I_CPU.fetch) O_FETCH_OPCODE <= opcode_eff;
    end

    wire soft_hit = I_CPU.exec_end && (opcode_eff == irq_seq_pkg::OPC_SOFT_TRAP);
    wire bad_hit  = I_CPU.opcode_undef;
    wire trap_hit = fetch_trap && trap_as_irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // pending latches and arbitration
    wire run       = state_q == irq_seq_pkg::ST_RUN;
    wire immediate = bad_hit || trap_hit;
    wire sample    = run && I_CPU.exec_end;
    logic [N_SRC-1:0] events;
    logic [N_SRC-1:0] eligible;
    logic [N_SRC-1:0] mask;
    logic             any_req;
    logic [3:0]       win_idx;

    genvar g;
    generate
        for (g = 0; g < N_SRC; g++) begin : g_src
            if (g == 0) begin : g_s
                assign events[g] = soft_hit;
                assign mask[g]   = 1'b1;
            end else if (g == 1) begin : g_b
                assign events[g] = bad_hit;
                assign mask[g]   = 1'b1;
            end else if (g == 2) begin : g_t
                assign events[g] = trap_hit;
                assign mask[g]   = 1'b1;
            end else if (g < irq_seq_pkg::FIRST_MASKABLE) begin : g_r
                assign events[g] = 1'b0;
                assign mask[g]   = 1'b0;
            end else begin : g_m
                assign events[g] = I_IRQ_SET[g];
                assign mask[g]   = master_en && enable_q[g];
            end
        end
    endgenerate

    // same-cycle events compete too, so immediate sources are taken at once
    assign eligible = (pend_q | events) & mask;

    irq_priority #(.N(N_SRC)) u_pri (
        .i_req (eligible),
        .o_any (any_req),
        .o_idx (win_idx)
    );

    wire start_accept = (sample || (immediate && state_q != irq_seq_pkg::ST_ACCEPT))
                        && any_req;
    wire [N_SRC-1:0] win_onehot = N_SRC'(1) << win_idx;

    always_comb begin
        pend_d = pend_q;
        if (wr_pend && wr_lo) pend_d[7:0]  = pend_q[7:0] & I_WDATA[7:0];
        if (wr_pend && wr_hi) pend_d[15:8] = pend_q[15:8] & I_WDATA[15:8];
        pend_d = pend_d | events;
        if (start_accept) pend_d = pend_d & ~win_onehot;
    end

    ////////////////////////////////////////////////////////////////////////////
    // acceptance and return sequencer
    wire [1:0] mcyc   = cnt_q[1:0];
    wire [2:0] mslot  = cnt_q[4:2];
    wire       edge_m = mcyc == irq_seq_pkg::MCYC_LAST;
    wire       last   = cnt_q == irq_seq_pkg::ACCEPT_LAST;
    wire [7:0] sp_minus3 = saved_sp_q - irq_seq_pkg::FRAME_BYTES;
    wire       ret_start = sample && !any_req && I_CPU.is_return;

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            state_q      <= irq_seq_pkg::ST_RUN;
            cnt_q        <= 6'h00;
            src_q        <= 4'h0;
            nmi_active_q <= 1'b0;
            saved_pc_q   <= 16'h0000;
            saved_sp_q   <= 8'h00;
            saved_st_q   <= 8'h00;
        end else begin
            case (state_q)
                irq_seq_pkg::ST_RUN, irq_seq_pkg::ST_RETURN: begin
                    if (start_accept) begin
                        state_q    <= irq_seq_pkg::ST_ACCEPT;
                        cnt_q      <= 6'h00;
                        src_q      <= win_idx;
                        saved_pc_q <= I_PC;
                        saved_sp_q <= I_SP;
                        saved_st_q <= {I_STATUS[7:1], master_en};
                    end else if (state_q == irq_seq_pkg::ST_RUN && ret_start) begin
                        state_q    <= irq_seq_pkg::ST_RETURN;
                        cnt_q      <= 6'h00;
                        saved_sp_q <= I_SP;
                    end else if (state_q == irq_seq_pkg::ST_RETURN) begin
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == 6'h03) begin
                            state_q      <= irq_seq_pkg::ST_RUN;
                            nmi_active_q <= 1'b0;
                        end
                    end
                end
                irq_seq_pkg::ST_ACCEPT: begin
                    cnt_q <= cnt_q + 6'h01;
                    if (last) begin
                        state_q      <= irq_seq_pkg::ST_RUN;
                        nmi_active_q <= src_q < irq_seq_pkg::FIRST_MASKABLE;
                    end
                end
                default: state_q <= irq_seq_pkg::ST_RUN;
            endcase
        end
    end

    // pushes in machine cycles 1..3
    wire acc  = state_q == irq_seq_pkg::ST_ACCEPT;
    wire return_nonmaskable = state_q == irq_seq_pkg::ST_RETURN;
    always_comb begin
        O_STACK = '0;
        if (acc && edge_m && mslot == 3'h1) begin
            O_STACK = '{1'b1, 1'b0, {8'h00, saved_sp_q}, saved_st_q};
        end else if (acc && edge_m && mslot == 3'h2) begin
            O_STACK = '{1'b1, 1'b0, {8'h00, 8'(saved_sp_q - 8'h01)}, saved_pc_q[15:8]};
        end else if (acc && edge_m && mslot == 3'h3) begin
            O_STACK = '{1'b1, 1'b0, {8'h00, 8'(saved_sp_q - 8'h02)}, saved_pc_q[7:0]};
        end else if (return_nonmaskable && cnt_q[1:0] != 2'h3) begin
            O_STACK = '{1'b0, 1'b1, {8'h00, 8'(saved_sp_q + 8'(cnt_q) + 8'h01)}, 8'h00};
        end
    end

    // return pops: cycle 0 pc low, 1 pc high, 2 status
    logic [7:0] pop_lo_q;
    logic [7:0] pop_hi_q;
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            pop_lo_q <= 8'h00;
            pop_hi_q <= 8'h00;
        end else if (return_nonmaskable && cnt_q == 6'h00) begin
            pop_lo_q <= I_STACK_RDATA;
        end else if (return_nonmaskable && cnt_q == 6'h01) begin
            pop_hi_q <= I_STACK_RDATA;
        end
    end

    wire ret_done = return_nonmaskable && cnt_q == 6'h02;
    assign O_VECTOR_ADDR  = irq_seq_pkg::VECTOR_TOP - {11'h0, src_q, 1'b0};
    assign O_PC_LOAD      = (acc && last) || ret_done;
    assign O_PC_VALUE     = ret_done ? {pop_hi_q, pop_lo_q} : I_VECTOR;
    assign O_SP_LOAD      = (acc && last) || ret_done;
    assign O_SP_VALUE     = ret_done ? 8'(saved_sp_q + irq_seq_pkg::FRAME_BYTES) : sp_minus3;
    assign O_STATUS_LOAD  = ret_done;
    assign O_STATUS_VALUE = I_STACK_RDATA;
    assign O_HOLD_CPU     = acc || return_nonmaskable;
    assign O_ABORT_INSTR  = immediate && any_req && !acc;
    assign O_TRAP_RESET   = fetch_trap && !trap_as_irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // enable register and latches
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            enable_q      <= irq_seq_pkg::ENABLE_RESET;
            trap_as_irq_q <= 1'b0;
            pend_q        <= '0;
        end else begin
            pend_q <= pend_d;
            if (wr_ctl && wr_lo) trap_as_irq_q <= I_WDATA[0];
            if (wr_en && wr_lo) enable_q[7:0]  <= {I_WDATA[7:4], 3'h0, I_WDATA[0]};
            if (wr_en && wr_hi) enable_q[15:8] <= I_WDATA[15:8];
            if (start_accept) enable_q[0] <= 1'b0;
            else if (ret_done) enable_q[0] <= I_STACK_RDATA[0];
        end
    end
endmodule

/* bench/irq_seq_props.sv */
`timescale 1ns/1ps
module irq_seq_props (
    // clock and reset
    input wire logic                   I_CLOCK,
    input wire logic                   I_RST,
    // bus
    input wire logic                   I_AWVALID,
    input wire logic                   I_WVALID,
    input wire logic                   O_AWREADY,
    input wire logic                   O_BVALID,
    input wire logic                   I_BREADY,
    input wire logic                   I_ARVALID,
    input wire logic                   O_ARREADY,
    input wire logic                   O_RVALID,
    // cpu side
    input wire irq_seq_pkg::cpu_evt_t  I_CPU,
    input wire logic                   I_MEM_EXISTS,
    input wire logic [15:0]            I_PC,
    input wire logic [7:0]             I_SP,
    input wire logic [7:0]             I_STACK_RDATA,
    input wire logic [15:0]            I_VECTOR,
    input wire irq_seq_pkg::stack_op_t O_STACK,
    input wire logic                   O_PC_LOAD,
    input wire logic [15:0]            O_PC_VALUE,
    input wire logic                   O_SP_LOAD,
    input wire logic [7:0]             O_SP_VALUE,
    input wire logic [7:0]             O_STATUS_VALUE,
    input wire logic                   O_HOLD_CPU,
    input wire logic [7:0]             O_FETCH_OPCODE
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    // start of an acceptance, not of a return
    sequence accept_s;
        $rose(O_HOLD_CPU) && !$past(I_CPU.is_return);
    endsequence
    accept_load_a: assert property (accept_s |-> ##31 O_PC_LOAD && O_SP_LOAD
        && O_PC_VALUE == I_VECTOR && O_SP_VALUE == I_SP - 8'h03) else $error("accept load");
    push_order_a: assert property (accept_s |-> ##7 (O_STACK.wr && O_STACK.addr[7:0] == I_SP)
        ##4 (O_STACK.wr && O_STACK.addr[7:0] == I_SP - 8'h01 && O_STACK.data == I_PC[15:8])
        ##4 (O_STACK.wr && O_STACK.addr[7:0] == I_SP - 8'h02 && O_STACK.data == I_PC[7:0]))
        else $error("push order");
    hold_run_a: assert property (accept_s |-> O_HOLD_CPU[*8] ##25 !O_HOLD_CPU)
        else $error("hold length");
    pop_order_a: assert property (O_STACK.rd && O_STACK.addr[7:0] == I_SP + 8'h01
        |=> O_STACK.rd && O_STACK.addr[7:0] == I_SP + 8'h02 ##1 O_STACK.rd && O_PC_LOAD
        && O_SP_VALUE == I_SP + 8'h03 && O_STATUS_VALUE == I_STACK_RDATA
        && O_PC_VALUE == {$past(I_STACK_RDATA), $past(I_STACK_RDATA, 2)}) else $error("pop order");
    take_point_a: assert property ($rose(O_HOLD_CPU) |-> $past(I_CPU.exec_end)
        || $past(I_CPU.opcode_undef) || $past(I_CPU.fetch)) else $error("take point");
    fetch_ff_a: assert property (I_CPU.fetch && !I_MEM_EXISTS |=> O_FETCH_OPCODE == 8'hFF)
        else $error("fetch opcode");
    undef_take_a: assert property (I_CPU.opcode_undef |=> O_HOLD_CPU)
        else $error("undef take");
    write_resp_a: assert property (I_AWVALID && I_WVALID && O_AWREADY |=> O_BVALID)
        else $error("write response");
    read_resp_a: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
        else $error("read response");
    bresp_done_a: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
        else $error("write response end");
    accept_c: cover property (accept_s ##31 O_PC_LOAD);
    pop_c: cover property (O_STACK.rd);
    undef_c: cover property (I_CPU.opcode_undef);
endmodule
bind irq_sequencer irq_seq_props u_irq_seq_props (.*);

/* bench/cpu_model.sv */
`timescale 1ns/1ps
module cpu_model #(
    parameter logic [15:0] PC0 = 16'h1234,
    parameter logic [7:0]  SP0 = 8'hF0
) (
    // clock and reset
    input  wire logic                   i_clock,
    input  wire logic                   i_rst,
    // from sequencer
    input  wire irq_seq_pkg::stack_op_t i_stack,
    input  wire logic [15:0]            i_vector_addr,
    input  wire logic                   i_pc_load,
    input  wire logic [15:0]            i_pc_value,
    input  wire logic                   i_sp_load,
    input  wire logic [7:0]             i_sp_value,
    input  wire logic                   i_status_load,
    input  wire logic [7:0]             i_status_value,
    // cpu state
    output logic [15:0]                 o_pc,
    output logic [7:0]                  o_sp,
    output logic [7:0]                  o_status,
    output logic [7:0]                  o_stack_rdata,
    output logic [15:0]                 o_vector
);
    logic [7:0] stack_q [256];
    // distinct entry per slot
    assign o_vector = i_vector_addr ^ 16'h7000;
    // inverse when not read
    assign o_stack_rdata = i_stack.rd ? stack_q[i_stack.addr[7:0]] : ~stack_q[i_stack.addr[7:0]];
    // only pc, sp, status and stack memory modelled
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_pc <= PC0;
            o_sp <= SP0;
            o_status <= 8'h5A;
        end else begin
            if (i_pc_load) o_pc <= i_pc_value;
            if (i_sp_load) o_sp <= i_sp_value;
            if (i_status_load) o_status <= i_status_value;
            if (i_stack.wr) stack_q[i_stack.addr[7:0]] <= i_stack.data;
        end
    end
endmodule

/* bench/irq_sequencer_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module irq_sequencer_tb_top;
    logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
    logic mem_exists = 1;
    logic [7:0] awaddr = 0, araddr = 0, sp_t = 8'hF0;
    logic [31:0] wdata = 0;
    logic [15:0] irq_set = 0, msk;
    logic [3:0] src_b;
    logic [33:0] exp_r, exp_rd[$];
    logic [23:0] exp_l, exp_ld[$];
    int checks = 0, mismatches = 0;
    irq_seq_pkg::cpu_evt_t cpu = '0;
    irq_seq_pkg::stack_op_t stack;
    wire awready, wready, bvalid, arready, rvalid, pc_load, sp_load, st_load, hold, trap_rst;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] vec_addr, pc_value, pc, vector;
    wire [7:0] sp_value, st_value, fetch_op, sp, status, stack_rdata;
    always #4 clk = ~clk;
    irq_sequencer u_irq_sequencer (.I_CLOCK(clk), .I_RST(rst), .I_AWADDR(awaddr),
        .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF),
        .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
        .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
        .I_IRQ_SET(irq_set), .I_CPU(cpu), .I_MEM_EXISTS(mem_exists), .I_PC(pc), .I_SP(sp),
        .I_STATUS(status), .I_STACK_RDATA(stack_rdata), .I_VECTOR(vector), .O_STACK(stack),
        .O_VECTOR_ADDR(vec_addr), .O_PC_LOAD(pc_load), .O_PC_VALUE(pc_value),
        .O_SP_LOAD(sp_load), .O_SP_VALUE(sp_value), .O_STATUS_LOAD(st_load),
        .O_STATUS_VALUE(st_value), .O_HOLD_CPU(hold), .O_ABORT_INSTR(),
        .O_FETCH_OPCODE(fetch_op), .O_TRAP_RESET(trap_rst));
    cpu_model u_cpu_model (.i_clock(clk), .i_rst(rst), .i_stack(stack), .i_vector_addr(vec_addr),
        .i_pc_load(pc_load), .i_pc_value(pc_value), .i_sp_load(sp_load), .i_sp_value(sp_value),
        .i_status_load(st_load), .i_status_value(st_value), .o_pc(pc), .o_sp(sp),
        .o_status(status), .o_stack_rdata(stack_rdata), .o_vector(vector));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(negedge clk); while (awready !== 1'b1);
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(negedge clk); while (bvalid !== 1'b1);
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_rd.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        @(posedge clk);
    endtask
    // pulse an event, wait out acceptance
    task automatic ev(input irq_seq_pkg::cpu_evt_t e);
        cpu <= e;
        @(posedge clk);
        cpu <= '0;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 60 && hold !== 1'b0; i++) @(posedge clk);
        @(posedge clk);
    endtask
    task automatic exp_acc(input logic [3:0] s);
        exp_ld.push_back({(irq_seq_pkg::VECTOR_TOP - 16'(2 * s)) ^ 16'h7000, sp_t - 8'h03});
        sp_t = sp_t - 8'h03;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            exp_r = exp_rd.pop_front();
            `CHK("read", exp_r, {rresp, rdata})
        end
        if (pc_load === 1'b1) begin
            exp_l = exp_ld.pop_front();
            `CHK("load", exp_l, {pc_value, sp_value})
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'hA8A9B685));
        src_b = 4'(6 + $urandom % 10);
        msk = (16'h0001 << 5) | (16'h0001 << src_b);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(irq_seq_pkg::REG_ENABLE, 34'h0);
        rd(8'h20, {irq_seq_pkg::RESP_SLVERR, 32'h0});
        wr(irq_seq_pkg::REG_ENABLE, {16'h0, msk});
        irq_set <= msk;
        @(posedge clk);
        irq_set <= '0;
        ev('{exec_end: 1'b1, default: '0});
        `CHK("hold", 1'b0, hold)
        rd(irq_seq_pkg::REG_PENDING, {18'h0, msk});
        wr(irq_seq_pkg::REG_ENABLE, {16'h0, msk | 16'h0001});
        exp_acc(4'h5);
        ev('{exec_end: 1'b1, default: '0});
        rd(irq_seq_pkg::REG_ENABLE, {18'h0, msk});
        rd(irq_seq_pkg::REG_PENDING, {18'h0, 16'h0001 << src_b});
        exp_ld.push_back({16'h1234, sp_t + 8'h03});
        sp_t = sp_t + 8'h03;
        ev('{exec_end: 1'b1, is_return: 1'b1, default: '0});
        rd(irq_seq_pkg::REG_ENABLE, {18'h0, msk | 16'h0001});
        exp_acc(src_b);
        ev('{exec_end: 1'b1, default: '0});
        irq_set <= 16'h0080;
        @(posedge clk);
        irq_set <= '0;
        wr(irq_seq_pkg::REG_PENDING, 32'h0);
        rd(irq_seq_pkg::REG_PENDING, 34'h0);
        wr(irq_seq_pkg::REG_PENDING, 32'h0000FFFF);
        rd(irq_seq_pkg::REG_PENDING, 34'h0);
        wr(irq_seq_pkg::REG_CONTROL, 32'h0);
        cpu <= '{fetch: 1'b1, fetch_addr: 16'h0100, default: '0};
        @(negedge clk);
        `CHK("trap reset", 1'b1, trap_rst)
        @(posedge clk);
        cpu <= '0;
        wr(irq_seq_pkg::REG_CONTROL, 32'h1);
        exp_acc(irq_seq_pkg::SRC_FETCH_TRAP);
        ev('{fetch: 1'b1, fetch_addr: 16'h0F90, default: '0});
        exp_acc(irq_seq_pkg::SRC_BAD_OPCODE);
        ev('{opcode_undef: 1'b1, default: '0});
        exp_acc(irq_seq_pkg::SRC_SOFT);
        ev('{exec_end: 1'b1, opcode: 8'hFF, default: '0});
        mem_exists <= 1'b0;
        cpu <= '{fetch: 1'b1, fetch_addr: 16'h8000, default: '0};
        @(posedge clk);
        cpu <= '0;
        @(negedge clk);
        `CHK("fetch opcode", irq_seq_pkg::OPC_SOFT_TRAP, fetch_op)
        wrap_up();
    end
endmodule
